// [rtl/core_irq_pkg.sv]
package core_irq_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TCY_NS        = 400;
  localparam int PHASES        = TCY_NS / CLK_PERIOD_NS;
  localparam logic [1:0] PH_Q1   = 2'h0;
  localparam logic [1:0] PH_LAST = 2'h3;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_OPT    = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PEN    = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PREQ   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_SHADOW = 8'h40;
  localparam int PER_REGS_MAX = 3;
  localparam int CTX_BYTES    = 6;

  // irq_control_reg fields
  localparam int B_GIE   = 7;
  localparam int B_PERIPHERAL_IRQ_ENABLE  = 6;
  localparam int B_CEN0  = 5;
  localparam int B_EXT_PIN_IRQ_ENABLE  = 4;
  localparam int B_CEN1  = 3;
  localparam int B_CFLG0 = 2;
  localparam int B_EXT_PIN_IRQ_FLAG  = 1;
  localparam int B_CFLG1 = 0;
  // option register: ext_pin_edge_select
  localparam int B_EDGE  = 0;
  // status bits kept out of the context
  localparam int B_TO    = 4;
  localparam int B_PD    = 3;

  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  OPT_RST  = 8'h01;
  localparam logic [14:0] IRQ_VECTOR = 15'h0004;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    S_RUN   = 2'h0,
    S_FLUSH = 2'h1,
    S_SAVE  = 2'h3,
    S_WAKE  = 2'h2
  } seq_t;

  typedef struct packed {
    logic [7:0] pc_high_latch;
    logic [7:0] fsr_hi;
    logic [7:0] fsr_lo;
    logic [7:0] bank_select_reg;
    logic [7:0] status;
    logic [7:0] w;
  } ctx_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic        return_from_isr;
    logic        sleep;
    logic [14:0] pc;
    ctx_t        ctx;
  } core_in_t;

  typedef struct packed {
    logic        flush;
    logic        push;
    logic [14:0] ret_pc;
    logic        load_vector;
    logic [14:0] vector;
    logic        pop;
    logic        restore;
    ctx_t        restore_ctx;
    logic        wake;
    logic        global_irq_enable;
    logic [1:0]  phase;
  } core_out_t;

endpackage

// [rtl/core_interrupt_sequencer.sv]
// Operation
// - Any reset leaves every interrupt disabled
// - Need global, own, and peripheral group enable
// - Flags set on event regardless of enables
// - Entry flushes prefetch, clears global, pushes PC
// - Vector loaded after context copied to shadows
// - Global off only records; pending fires later
// - Return pops, restores context, sets global
// - Synchronous latency three or four cycles
// - Asynchronous latency three to five cycles
// - Latency independent of instruction length
// - Pin flag sampled at first phase
// - Pin flag may set any phase
// - Wake branches only if global enable set
// - Instruction after sleep always executes first
// - Pin gives edge interrupt, own enable
// - Edge select: set rising, clear falling
// - Valid edge sets pin flag, redirects
// - Entry saves working, status, bank, pointers, latch
// - Return overwrites registers from shadows
// - Shadows readable and writable by software
//
// Our own choices: the address map and register access over AXI4-Lite.
module core_interrupt_sequencer #(
  parameter int N_PER_REGS = 3
) (
  input  wire logic                   clk_i,
  input  wire logic                   resetn_i,
  input  wire core_irq_pkg::axi_req_t axi_i,
  output      core_irq_pkg::axi_rsp_t axi_o,
  input  wire core_irq_pkg::core_in_t core_i,
  output      core_irq_pkg::core_out_t core_o,
  input  wire logic [1:0]             core_evt_i,
  input  wire logic [23:0]            per_evt_i,
  input  wire logic                   ext_pin_i
);
  import core_irq_pkg::*;

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (N_PER_REGS < 1 || N_PER_REGS > PER_REGS_MAX) begin : g_bad_regs
    $error("N_PER_REGS must be 1 to 3");
  end
  if (PHASES != 4) begin : g_bad_phases
    $error("Instruction cycle must be four clocks");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    seq_t                               seq;
    logic [1:0]                         phase;
    logic [7:0]                         ctrl;
    logic [7:0]                         opt;
    logic [PER_REGS_MAX-1:0][7:0]       pen;
    logic [PER_REGS_MAX-1:0][7:0]       preq;
    logic [CTX_BYTES-1:0][7:0]          shadow;
    logic                               pin_prev;
    logic                               aw_have;
    logic [ADDR_W-1:0]                  aw_addr;
    logic                               w_have;
    logic [7:0]                         w_data;
    logic                               w_en;
    axi_rsp_t                           axi;
    core_out_t                          out;
  } st_t;

  st_t q;
  st_t d;

  // Word-aligned match of a byte address against a register offset
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction

  // Peripheral register index for a base offset, or none
  function automatic logic [2:0] per_sel(input logic [ADDR_W-1:0] a,
                                         input logic [ADDR_W-1:0] base);
    per_sel = 3'h0;
    for (int k = 0; k < N_PER_REGS; k++) begin
      if (hit(a, base + ADDR_W'(4 * k))) begin
        per_sel = 3'(k + 1);
      end
    end
  endfunction

  // Shadow register index, or none
  function automatic logic [2:0] shd_sel(input logic [ADDR_W-1:0] a);
    shd_sel = 3'h0;
    for (int k = 0; k < CTX_BYTES; k++) begin
      if (hit(a, OFF_SHADOW + ADDR_W'(4 * k))) begin
        shd_sel = 3'(k + 1);
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // Request forming (from registered state only)
  // ----------------------------------------------------------------------
  logic [PER_REGS_MAX-1:0] per_hit;
  logic                    core_hit;
  logic                    req_any;
  logic                    irq_w;
  logic                    q1_w;

  // Per-register peripheral pairs
  for (genvar g = 0; g < PER_REGS_MAX; g++) begin : g_per
    if (g < N_PER_REGS) begin : g_on
      assign per_hit[g] = |(q.preq[g] & q.pen[g]);
    end else begin : g_off
      assign per_hit[g] = 1'b0;
    end
  end

  // pin flag counts only with its enable
  // core pairs plus gated peripheral group
  assign core_hit = (q.ctrl[B_CFLG0] & q.ctrl[B_CEN0])
                  | (q.ctrl[B_EXT_PIN_IRQ_FLAG]  & q.ctrl[B_EXT_PIN_IRQ_ENABLE])
                  | (q.ctrl[B_CFLG1] & q.ctrl[B_CEN1]);
  // peripheral group needs its own enable
  assign req_any  = core_hit | (q.ctrl[B_PERIPHERAL_IRQ_ENABLE] & (|per_hit));
  assign irq_w    = q.ctrl[B_GIE] & req_any;
  assign q1_w     = (q.phase == PH_Q1);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic             pin_edge;
    logic             wr_fire;
    logic [2:0]       wp;
    logic [2:0]       ws;
    logic [2:0]       rp;
    logic [2:0]       rq;
    logic [2:0]       rs;
    logic [31:0]      rd;
    logic             rd_ok;
    logic             wr_ok;
    logic [PER_REGS_MAX*8-1:0] pev;
    ctx_t             sh;
    pin_edge = 1'b0;
    wr_fire  = 1'b0;
    wp       = 3'h0;
    ws       = 3'h0;
    rp       = 3'h0;
    rq       = 3'h0;
    rs       = 3'h0;
    rd       = 32'h0000_0000;
    rd_ok    = 1'b0;
    wr_ok    = 1'b0;
    pev      = per_evt_i;
    sh       = ctx_t'(q.shadow);
    d        = q;

    // Pulses last one clock
    d.out.flush       = 1'b0;
    d.out.push        = 1'b0;
    d.out.load_vector = 1'b0;
    d.out.pop         = 1'b0;
    d.out.restore     = 1'b0;
    d.out.wake        = 1'b0;

    // Q1..Q4 phase counter, one instruction cycle per wrap
    d.phase = (q.phase == PH_LAST) ? PH_Q1 : q.phase + 2'h1;

    // edge select picks rising or falling
    d.pin_prev = ext_pin_i;
    pin_edge   = q.opt[B_EDGE] ? (ext_pin_i & ~q.pin_prev)
                               : (~ext_pin_i & q.pin_prev);

    // AXI write channels taken in either order
    if (axi_i.awvalid && q.axi.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = axi_i.awaddr;
    end
    if (axi_i.wvalid && q.axi.wready) begin
      d.w_have = 1'b1;
      d.w_data = axi_i.wdata[7:0];
      d.w_en   = axi_i.wstrb[0];
    end
    if (q.axi.bvalid && axi_i.bready) begin
      d.axi.bvalid = 1'b0;
    end
    wr_fire = q.aw_have && q.w_have && !q.axi.bvalid;

    // Register writes; only byte lane 0 carries data
    if (wr_fire) begin
      wp = per_sel(q.aw_addr, OFF_PEN);
      ws = shd_sel(q.aw_addr);
      wr_ok = hit(q.aw_addr, OFF_CTRL) || hit(q.aw_addr, OFF_OPT)
           || (wp != 3'h0) || (per_sel(q.aw_addr, OFF_PREQ) != 3'h0)
           || (ws != 3'h0);
      if (q.w_en) begin
        if (hit(q.aw_addr, OFF_CTRL)) begin
          d.ctrl = q.w_data;
        end
        if (hit(q.aw_addr, OFF_OPT)) begin
          d.opt = {7'h00, q.w_data[B_EDGE]};
        end
        if (wp != 3'h0) begin
          d.pen[wp - 3'h1] = q.w_data;
        end
        if (per_sel(q.aw_addr, OFF_PREQ) != 3'h0) begin
          d.preq[per_sel(q.aw_addr, OFF_PREQ) - 3'h1] = q.w_data;
        end
        if (ws != 3'h0) begin
          d.shadow[ws - 3'h1] = q.w_data;
        end
      end
      d.aw_have   = 1'b0;
      d.w_have    = 1'b0;
      d.axi.bvalid = 1'b1;
      d.axi.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    // One write at a time: no new address or data until answered
    d.axi.awready = !d.aw_have && !d.axi.bvalid;
    d.axi.wready  = !d.w_have && !d.axi.bvalid;

    // Read: answered the clock after the address is taken
    if (q.axi.rvalid && axi_i.rready) begin
      d.axi.rvalid = 1'b0;
    end
    if (axi_i.arvalid && q.axi.arready) begin
      rp = per_sel(axi_i.araddr, OFF_PEN);
      rq = per_sel(axi_i.araddr, OFF_PREQ);
      rs = shd_sel(axi_i.araddr);
      rd_ok = 1'b1;
      if (hit(axi_i.araddr, OFF_CTRL)) begin
        rd = {24'h000000, q.ctrl};
      end else if (hit(axi_i.araddr, OFF_OPT)) begin
        rd = {24'h000000, q.opt};
      end else if (rp != 3'h0) begin
        rd = {24'h000000, q.pen[rp - 3'h1]};
      end else if (rq != 3'h0) begin
        rd = {24'h000000, q.preq[rq - 3'h1]};
      end else if (rs != 3'h0) begin
        rd = {24'h000000, q.shadow[rs - 3'h1]};
      end else begin
        rd_ok = 1'b0;
      end
      d.axi.rvalid = 1'b1;
      d.axi.rdata  = rd;
      d.axi.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    d.axi.arready = !d.axi.rvalid;

    // Sequencer; interrupt decisions only on Q1 samples, return taken in any phase
    unique case (q.seq)
      S_RUN: begin
        if (core_i.return_from_isr) begin
          d.out.pop         = 1'b1;
          d.out.restore     = 1'b1;
          d.ctrl[B_GIE]     = 1'b1;
          d.out.restore_ctx = sh;
          d.out.restore_ctx.status[B_TO] = core_i.ctx.status[B_TO];
          d.out.restore_ctx.status[B_PD] = core_i.ctx.status[B_PD];
        // pending state sampled on Q1 only
        end else if (q1_w) begin
          if (core_i.sleep) begin
            // any enabled source wakes; vector only if global set
            if (req_any) begin
              d.out.wake = 1'b1;
              d.seq      = S_WAKE;
            end
          end else if (irq_w) begin
            // flush and drop global enable at once
            d.out.flush   = 1'b1;
            d.ctrl[B_GIE] = 1'b0;
            d.seq         = S_FLUSH;
          end
        end
      end
      S_WAKE: begin
        // one whole cycle for the post-sleep instruction
        if (q1_w) begin
          d.seq = S_RUN;
        end
      end
      S_FLUSH: begin
        // one entry path for every source
        // fixed wait, so instruction length has no say
        if (q1_w) begin
          d.out.push   = 1'b1;
          d.out.ret_pc = core_i.pc;
          // context copy, status without timeout and powerdown
          sh.w      = core_i.ctx.w;
          sh.bank_select_reg    = core_i.ctx.bank_select_reg;
          sh.fsr_lo = core_i.ctx.fsr_lo;
          sh.fsr_hi = core_i.ctx.fsr_hi;
          sh.pc_high_latch = core_i.ctx.pc_high_latch;
          sh.status = {core_i.ctx.status[7:5], sh.status[4:3],
                       core_i.ctx.status[2:0]};
          d.shadow  = sh;
          d.seq     = S_SAVE;
        end
      end
      S_SAVE: begin
        // vector follows the context copy by one clock
        d.out.load_vector = 1'b1;
        d.out.vector      = IRQ_VECTOR;
        d.seq             = S_RUN;
      end
    endcase

    // events set flags whatever the enables; set beats clear
    if (core_evt_i[0]) begin
      d.ctrl[B_CFLG0] = 1'b1;
    end
    if (core_evt_i[1]) begin
      d.ctrl[B_CFLG1] = 1'b1;
    end
    // pin flag may set in any phase
    // valid edge sets the pin flag
    if (pin_edge) begin
      d.ctrl[B_EXT_PIN_IRQ_FLAG] = 1'b1;
    end
    for (int k = 0; k < N_PER_REGS; k++) begin
      d.preq[k] = d.preq[k] | pev[k*8 +: 8];
    end

    d.out.global_irq_enable   = d.ctrl[B_GIE];
    d.out.phase = d.phase;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // reset clears every enable and leaves the sequencer idle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q          <= '0;
      q.seq      <= S_RUN;
      q.ctrl     <= CTRL_RST;
      q.opt      <= OPT_RST;
      q.out.vector <= IRQ_VECTOR;
    end else begin
      q <= d;
    end
  end

  assign axi_o  = q.axi;
  assign core_o = q.out;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  logic wr_seen;
  assign wr_seen = q.aw_have && q.w_have && !q.axi.bvalid;

  property p_gie_rise;
    @(posedge clk_i) disable iff (!resetn_i)
      $rose(q.ctrl[B_GIE]) |-> $past(wr_seen) || core_o.pop;
  endproperty
  a_gie_rise: assert property (p_gie_rise)
    else $error("global enable rose without write or return");

  property p_flush_cause;
    @(posedge clk_i) disable iff (!resetn_i)
      $rose(core_o.flush) |-> $past(irq_w) && !core_o.global_irq_enable;
  endproperty
  a_flush_cause: assert property (p_flush_cause)
    else $error("flush without enabled request or global still set");

  property p_take_pending;
    @(posedge clk_i) disable iff (!resetn_i)
      (q.seq == S_RUN && q1_w && irq_w && !core_i.sleep
       && !core_i.return_from_isr) |=> core_o.flush;
  endproperty
  a_take_pending: assert property (p_take_pending)
    else $error("pending enabled request not taken on Q1");

  property p_entry_seq;
    @(posedge clk_i) disable iff (!resetn_i)
      core_o.flush |-> ##4 core_o.push ##1 core_o.load_vector;
  endproperty
  a_entry_seq: assert property (p_entry_seq)
    else $error("entry sequence timing wrong");

  property p_vector;
    @(posedge clk_i) disable iff (!resetn_i)
      core_o.load_vector |-> core_o.vector == IRQ_VECTOR
                             && $past(core_o.push);
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector load wrong or not after context copy");

  property p_q1_sample;
    @(posedge clk_i) disable iff (!resetn_i)
      core_o.flush |-> core_o.phase == 2'h1;
  endproperty
  a_q1_sample: assert property (p_q1_sample)
    else $error("redirect decided outside Q1");

  property p_return;
    @(posedge clk_i) disable iff (!resetn_i)
      ($past(q.seq) == S_RUN && $past(core_i.return_from_isr))
        |-> core_o.pop && core_o.restore && core_o.global_irq_enable;
  endproperty
  a_return: assert property (p_return)
    else $error("return did not pop, restore and enable");

  property p_wake_hold;
    @(posedge clk_i) disable iff (!resetn_i)
      core_o.wake |=> !core_o.flush [*5];
  endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("redirect before post-sleep instruction");

  property p_pin_edge;
    @(posedge clk_i) disable iff (!resetn_i)
      (q.opt[B_EDGE] && $rose(ext_pin_i)) ||
      (!q.opt[B_EDGE] && $fell(ext_pin_i)) |=> q.ctrl[B_EXT_PIN_IRQ_FLAG];
  endproperty
  a_pin_edge: assert property (p_pin_edge)
    else $error("active pin edge did not set pin flag");

  property p_save_w;
    @(posedge clk_i) disable iff (!resetn_i)
      core_o.push |-> q.shadow[0] == $past(core_i.ctx.w)
                      && q.shadow[5] == $past(core_i.ctx.pc_high_latch);
  endproperty
  a_save_w: assert property (p_save_w)
    else $error("context not copied to shadows on entry");

endmodule

// [bench/core_model.sv]
module core_model (
  input  wire logic                    clk_i,
  input  wire logic                    resetn_i,
  input  wire core_irq_pkg::core_out_t seq_i,
  input  wire logic                    ret_i,
  input  wire logic                    sleep_i,
  output      core_irq_pkg::core_in_t  core_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import core_irq_pkg::*;

  core_in_t    st_q;
  logic [14:0] stack_q;

  assign core_o = st_q;

  // ----------------------------------------------------------------------
  // Core stand-in
  // ----------------------------------------------------------------------
  // Pc simply advances each clock in place of real fetch
  // stack, vector and context
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q     <= '0;
      st_q.ctx <= 48'h605040302010;
      stack_q  <= '0;
    end else begin
      st_q.return_from_isr <= ret_i;
      st_q.sleep  <= sleep_i;
      st_q.pc     <= st_q.pc + 15'h1;
      if (seq_i.push) begin
        stack_q <= seq_i.ret_pc;
      end
      if (seq_i.load_vector) begin
        st_q.pc <= seq_i.vector;
      end
      if (seq_i.pop) begin
        st_q.pc <= stack_q;
      end
      if (seq_i.restore) begin
        st_q.ctx <= seq_i.restore_ctx;
      end
    end
  end
endmodule

// [bench/test_core_interrupt_sequencer.sv]
module test_core_interrupt_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  import core_irq_pkg::*;

  logic        clk_i    = 1'b0;
  logic        resetn_i = 1'b0;
  axi_req_t    axi_q    = '0;
  axi_rsp_t    axi_o;
  core_in_t    core_i;
  core_out_t   core_o;
  logic [1:0]  evt_q    = 2'h0;
  logic [23:0] per_q    = 24'h0;
  logic        pin_q    = 1'b0;
  logic        ret_q    = 1'b0;
  logic        sleep_q  = 1'b0;
  int          num_errors   = 0;
  int          total_checks = 0;
  int          cyc          = 0;
  int          t;

  core_interrupt_sequencer #(.N_PER_REGS(3)) i_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .axi_i(axi_q), .axi_o(axi_o),
    .core_i(core_i), .core_o(core_o), .core_evt_i(evt_q),
    .per_evt_i(per_q), .ext_pin_i(pin_q));

  core_model i_core (
    .clk_i(clk_i), .resetn_i(resetn_i), .seq_i(core_o), .ret_i(ret_q),
    .sleep_i(sleep_q), .core_o(core_i));

  always #50 clk_i = ~clk_i;

  // Hang guard, well above the few hundred cycles used
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw;
    logic w;
    aw = 1'b0;
    w  = 1'b0;
    @(posedge clk_i);
    axi_q.awaddr  <= a;
    axi_q.wdata   <= {24'h0, d};
    axi_q.wstrb   <= 4'hF;
    axi_q.awvalid <= 1'b1;
    axi_q.wvalid  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk_i);
      if (axi_q.awvalid && axi_o.awready === 1'b1) begin
        aw = 1'b1;
        axi_q.awvalid <= 1'b0;
      end
      if (axi_q.wvalid && axi_o.wready === 1'b1) begin
        w = 1'b1;
        axi_q.wvalid <= 1'b0;
      end
    end
    axi_q.bready <= 1'b1;
    do @(posedge clk_i); while (axi_o.bvalid !== 1'b1);
    check("bresp", axi_o.bresp, RESP_OKAY);
    axi_q.bready <= 1'b0;
  endtask

  // Reads one word and compares data and response
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] resp, input string what);
    @(posedge clk_i);
    axi_q.araddr  <= a;
    axi_q.arvalid <= 1'b1;
    do @(posedge clk_i); while (axi_o.arready !== 1'b1);
    axi_q.arvalid <= 1'b0;
    axi_q.rready  <= 1'b1;
    do @(posedge clk_i); while (axi_o.rvalid !== 1'b1);
    axi_q.rready <= 1'b0;
    check(what, axi_o.rdata, exp);
    check(what, axi_o.rresp, resp);
  endtask

  // Cycles until pulse k shows, 0 if already up at the call
  // 5 flush 4 push 3 vector 2 pop 0 wake
  task automatic seek(input int k, input int lim, output int t);
    logic [5:0] p;
    t = -1;
    for (int i = 0; i <= lim && t < 0; i++) begin
      if (i > 0) begin
        @(posedge clk_i);
      end
      #1;
      p = {core_o.flush, core_o.push, core_o.load_vector,
           core_o.pop, core_o.restore, core_o.wake};
      if (p[k] === 1'b1) begin
        t = i;
      end
    end
  endtask

  task automatic entry(input int lim, output int tot);
    int tf;
    int tp;
    int tv;
    seek(5, lim, tf);
    check("entry_seen", tf >= 0, 1);
    seek(4, 8, tp);
    check("push_gap", tp, 4);
    check("ret_pc", core_o.ret_pc, 15'(core_i.pc - 15'h1));
    seek(3, 4, tv);
    check("vector_gap", tv, 1);
    check("vector", core_o.vector, IRQ_VECTOR);
    check("gie_cleared", core_o.global_irq_enable, 1'b0);
    tot = tf + tp + tv + 1;
  endtask

  task automatic pulse_evt();
    evt_q <= 2'h1;
    @(posedge clk_i);
    evt_q <= 2'h0;
  endtask

  task automatic leave_isr();
    ret_q <= 1'b1;
    @(posedge clk_i);
    ret_q <= 1'b0;
    seek(2, 4, t);
    check("pop", t > 0, 1);
    check("restore", core_o.restore, 1'b1);
    check("gie_set", core_o.global_irq_enable, 1'b1);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check("gie_reset", core_o.global_irq_enable, 1'b0);
    rd_chk(OFF_CTRL, 32'h0, RESP_OKAY, "ctrl_reset");
    rd_chk(OFF_OPT, 32'h1, RESP_OKAY, "opt_reset");
    rd_chk(8'h30, 32'h0, RESP_SLVERR, "unmapped");
    // Flag records with every enable off
    pulse_evt();
    rd_chk(OFF_CTRL, 32'h04, RESP_OKAY, "flag_set");
    seek(5, 12, t);
    check("no_entry_off", t, -1);
    // Pending flag fires once enables come on
    wr(OFF_CTRL, 8'hA4);
    entry(24, t);
    rd_chk(OFF_SHADOW, 32'h10, RESP_OKAY, "shadow_w");
    wr(OFF_SHADOW, 8'h77);
    wr(OFF_CTRL, 8'h20);
    leave_isr();
    check("ctx_back", core_o.restore_ctx.w, 8'h77);
    seek(5, 12, t);
    check("no_reentry", t, -1);
    // Fresh event while running enabled
    pulse_evt();
    entry(20, t);
    check("latency", t <= 4 * PHASES, 1);
    wr(OFF_CTRL, 8'h20);
    leave_isr();
    // Peripheral source needs the group enable
    wr(OFF_PEN, 8'h01);
    wr(OFF_CTRL, 8'h80);
    per_q <= 24'h1;
    @(posedge clk_i);
    per_q <= 24'h0;
    rd_chk(OFF_PREQ, 32'h01, RESP_OKAY, "per_flag");
    seek(5, 12, t);
    check("no_entry_peripheral_irq_enable", t, -1);
    wr(OFF_CTRL, 8'hC0);
    entry(24, t);
    wr(OFF_PREQ, 8'h00);
    wr(OFF_CTRL, 8'h00);
    leave_isr();
    // Pin set for falling edge: rise ignored, fall taken
    wr(OFF_OPT, 8'h00);
    wr(OFF_CTRL, 8'h90);
    pin_q <= 1'b1;
    seek(5, 12, t);
    check("rise_ignored", t, -1);
    pin_q <= 1'b0;
    entry(24, t);
    check("pin_latency", t <= 5 * PHASES, 1);
    rd_chk(OFF_CTRL, 32'h12, RESP_OKAY, "pin_flag");
    // Wake with global enable off: no branch
    // source enabled before sleep
    wr(OFF_CTRL, 8'h20);
    sleep_q <= 1'b1;
    pulse_evt();
    seek(0, 12, t);
    check("wake", t > 0, 1);
    sleep_q <= 1'b0;
    seek(5, 16, t);
    check("no_branch_wake", t, -1);
    // Wake with global enable on: branch after the wake
    sleep_q <= 1'b1;
    wr(OFF_CTRL, 8'hA4);
    seek(0, 12, t);
    check("wake_gie", t >= 0, 1);
    sleep_q <= 1'b0;
    entry(24, t);
    close_out();
  end
endmodule
